// ==== include/logic_datapath_pkg.sv ====
// shared constants and types of the programmable logic datapath
package logic_datapath_pkg;
  localparam int DATA_W      = 8;
  localparam int CFG_W       = 16;
  localparam int CFG_DEPTH   = 8;
  localparam int QUEUE_DEPTH = 4;
  localparam int SEL_W       = 3;

  // =====================================================
  // configuration word fields
  localparam int F_OP_LSB    = 0;
  localparam int F_SRCA      = 3;
  localparam int F_SRCB_LSB  = 4;
  localparam int F_SHIFT_LSB = 6;
  localparam int F_MASK      = 8;
  localparam int F_DEST_LSB  = 9;
  localparam int F_Q0_LSB    = 11;
  localparam int F_Q1_LSB    = 13;
  localparam int F_LOAD_ACC  = 15;

  typedef enum logic [2:0] {
    OP_INC, OP_DEC, OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_PASS
  } alu_op_type;

  localparam logic [1:0] SH_NONE  = 2'h0;
  localparam logic [1:0] SH_LEFT  = 2'h1;
  localparam logic [1:0] SH_RIGHT = 2'h2;
  localparam logic [1:0] SH_SWAP  = 2'h3;

  localparam logic [1:0] QM_IDLE    = 2'h0;
  localparam logic [1:0] QM_CAP_ACC = 2'h1;
  localparam logic [1:0] QM_CAP_ALU = 2'h2;
  localparam logic [1:0] QM_LOAD    = 2'h3;

  // =====================================================
  // working register selects on the system bus port
  localparam logic [2:0] SEL_ACC0 = 3'h0;
  localparam logic [2:0] SEL_ACC1 = 3'h1;
  localparam logic [2:0] SEL_OPR0 = 3'h2;
  localparam logic [2:0] SEL_OPR1 = 3'h3;
  localparam logic [2:0] SEL_Q0   = 3'h4;
  localparam logic [2:0] SEL_Q1   = 3'h5;

  localparam logic [7:0]  REG_RESET = 8'h00;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  localparam logic [7:0]  OR_MASK_DEFAULT = 8'hf0;
endpackage

// ==== rtl/byte_queue.sv ====
// small valid/ready queue holding datapath bytes
`timescale 1ns/1ps
`default_nettype none
module byte_queue #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             sys_clk_in,
  input  wire logic             reset_in,
  input  wire logic             ce_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad
    $error("byte_queue depth must be a power of two, at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               rd;
    logic [AW-1:0]               wr;
    logic [AW:0]                 count;
  } queue_state_type;

  queue_state_type st;
  queue_state_type next_st;
  logic            push;
  logic            pop;

  assign in_ready_out  = st.count != (AW+1)'(DEPTH);
  assign out_valid_out = st.count != '0;
  assign out_data_out  = st.mem[st.rd];

  always_comb begin
    next_st = st;
    push = ce_in && in_valid_in && in_ready_out;
    pop  = ce_in && out_valid_out && out_ready_in;
    if (push) begin
      next_st.mem[st.wr] = in_data_in;
      next_st.wr = st.wr + 1'b1;
    end
    if (pop) begin
      next_st.rd = st.rd + 1'b1;
    end
    next_st.count = st.count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  property p_queue_depth;
    @(posedge sys_clk_in) disable iff (reset_in)
      (st.count <= (AW+1)'(DEPTH)) && (in_ready_out == (st.count < (AW+1)'(DEPTH)));
  endproperty
  a_queue_depth: assert property (p_queue_depth)
    else $error("queue holds more than its depth");
endmodule
`default_nettype wire

// ==== rtl/config_store.sv ====
// eight-word configuration memory, read without latency
`timescale 1ns/1ps
`default_nettype none
module config_store #(
  parameter int WORDS = 8,
  parameter int WIDTH = 16
) (
  input  wire logic                     sys_clk_in,
  input  wire logic                     reset_in,
  input  wire logic                     ce_in,
  input  wire logic                     wr_en_in,
  input  wire logic [$clog2(WORDS)-1:0] wr_addr_in,
  input  wire logic [WIDTH-1:0]         wr_data_in,
  input  wire logic [$clog2(WORDS)-1:0] rd_addr_in,
  output logic      [WIDTH-1:0]         rd_word_out
);
  if (WORDS < 2 || WIDTH != logic_datapath_pkg::CFG_W) begin : g_bad
    $error("config_store needs at least two words of the config width");
  end

  typedef struct packed {
    logic [WORDS-1:0][WIDTH-1:0] mem;
  } cfg_state_type;

  cfg_state_type st;
  cfg_state_type next_st;

  assign rd_word_out = st.mem[rd_addr_in];

  always_comb begin
    next_st = st;
    if (ce_in && wr_en_in) begin
      next_st.mem[wr_addr_in] = wr_data_in;
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      st <= {WORDS{logic_datapath_pkg::CFG_RESET}};
    end else begin
      st <= next_st;
    end
  end

  property p_cfg_write;
    @(posedge sys_clk_in) disable iff (reset_in)
      ce_in && wr_en_in |=> (rd_addr_in == $past(wr_addr_in)) -> (rd_word_out == $past(wr_data_in));
  endproperty
  a_cfg_write: assert property (p_cfg_write)
    else $error("config word not stored");
endmodule
`default_nettype wire

// ==== rtl/logic_datapath.sv ====
// datapath slice: accumulators, operand registers, alu, queues, config memory
// What this block does
// - six working registers reachable by cpu and dma
// - accumulators feed alu, take results, feed compares
// - operand registers feed alu and compares only
// - queues are bus interface, load registers
// - queues capture accumulator or alu output
// - each queue holds four bytes
// - eight sixteen-bit configuration words
// - function may change every clock cycle
// - addressed word selects the active configuration
// - alu: inc dec add sub and or xor pass
// - pass forwards operand unchanged
// - shift, swap, or-mask follow any alu operation
`timescale 1ns/1ps
`default_nettype none
module logic_datapath #(
  parameter logic [7:0] OR_MASK     = logic_datapath_pkg::OR_MASK_DEFAULT,
  parameter int         QUEUE_DEPTH = logic_datapath_pkg::QUEUE_DEPTH
) (
  input  wire logic        sys_clk_in,
  input  wire logic        reset_in,
  input  wire logic        ce_in,
  input  wire logic [2:0]  cfg_addr_in,
  input  wire logic        cfg_wr_en_in,
  input  wire logic [2:0]  cfg_wr_addr_in,
  input  wire logic [15:0] cfg_wr_data_in,
  input  wire logic        bus_wr_en_in,
  input  wire logic        bus_rd_en_in,
  input  wire logic [2:0]  bus_sel_in,
  input  wire logic [7:0]  bus_wdata_in,
  output logic      [7:0]  bus_rdata_out,
  output logic             bus_rvalid_out,
  output logic             bus_err_out,
  output logic      [7:0]  alu_out,
  output logic      [1:0]  cmp_eq_out,
  output logic      [1:0]  cmp_lt_out,
  output logic      [1:0]  q_empty_out,
  output logic      [1:0]  q_full_out,
  output logic             stall_out
);
  localparam int W = logic_datapath_pkg::DATA_W;

  if (QUEUE_DEPTH < 2) begin : g_bad
    $error("logic_datapath needs queues of at least two entries");
  end

  typedef struct packed {
    logic [1:0][W-1:0] acc;
    logic [1:0][W-1:0] opr;
    logic [W-1:0]      rdata;
    logic              rvalid;
    logic              err;
    logic [W-1:0]      alu;
    logic [1:0]        eq;
    logic [1:0]        lt;
    logic [1:0]        q_empty;
    logic [1:0]        q_full;
    logic              stall;
  } dp_state_type;

  dp_state_type st;
  dp_state_type next_st;

  // =====================================================
  // configuration select
  logic [15:0]                    cfg;
  logic_datapath_pkg::alu_op_type op;
  logic [1:0]                     shift_sel;
  logic                           mask_en;
  logic [1:0]                     dest;
  logic                           load_acc;
  logic [1:0][1:0]                qmode;

  config_store #(
    .WORDS (logic_datapath_pkg::CFG_DEPTH),
    .WIDTH (logic_datapath_pkg::CFG_W)
  ) u_cfg (
    .sys_clk_in  (sys_clk_in),
    .reset_in    (reset_in),
    .ce_in       (ce_in),
    .wr_en_in    (cfg_wr_en_in),
    .wr_addr_in  (cfg_wr_addr_in),
    .wr_data_in  (cfg_wr_data_in),
    .rd_addr_in  (cfg_addr_in),
    .rd_word_out (cfg)
  );

  // the addressed word steers this very cycle's operation
  assign op        = logic_datapath_pkg::alu_op_type'(cfg[logic_datapath_pkg::F_OP_LSB +: 3]);
  assign shift_sel = cfg[logic_datapath_pkg::F_SHIFT_LSB +: 2];
  assign mask_en   = cfg[logic_datapath_pkg::F_MASK];
  assign dest      = cfg[logic_datapath_pkg::F_DEST_LSB +: 2];
  assign load_acc  = cfg[logic_datapath_pkg::F_LOAD_ACC];
  assign qmode[0]  = cfg[logic_datapath_pkg::F_Q0_LSB +: 2];
  assign qmode[1]  = cfg[logic_datapath_pkg::F_Q1_LSB +: 2];

  // =====================================================
  // operands and alu
  function automatic logic [W-1:0] pick_src(input logic [1:0] sel,
                                            input logic [1:0][W-1:0] acc,
                                            input logic [1:0][W-1:0] opr);
    pick_src = sel[1] ? acc[sel[0]] : opr[sel[0]];
  endfunction

  logic [W-1:0] a_val;
  logic [W-1:0] b_val;
  logic [W-1:0] add_ref;
  logic [W-1:0] alu_raw;
  logic [W-1:0] shifted;
  logic [W-1:0] result;

  assign a_val   = pick_src({1'b1, cfg[logic_datapath_pkg::F_SRCA]}, st.acc, st.opr);
  assign b_val   = pick_src(cfg[logic_datapath_pkg::F_SRCB_LSB +: 2], st.acc, st.opr);
  assign add_ref = W'(a_val + b_val);

  always_comb begin
    case (op)
      logic_datapath_pkg::OP_INC:  alu_raw = W'(a_val + 1'b1);
      logic_datapath_pkg::OP_DEC:  alu_raw = W'(a_val - 1'b1);
      logic_datapath_pkg::OP_ADD:  alu_raw = W'(a_val + b_val);
      logic_datapath_pkg::OP_SUB:  alu_raw = W'(a_val - b_val);
      logic_datapath_pkg::OP_AND:  alu_raw = a_val & b_val;
      logic_datapath_pkg::OP_OR:   alu_raw = a_val | b_val;
      logic_datapath_pkg::OP_XOR:  alu_raw = a_val ^ b_val;
      logic_datapath_pkg::OP_PASS: alu_raw = a_val;
      default:                     alu_raw = a_val;
    endcase
    case (shift_sel)
      logic_datapath_pkg::SH_LEFT:  shifted = {alu_raw[W-2:0], 1'b0};
      logic_datapath_pkg::SH_RIGHT: shifted = {1'b0, alu_raw[W-1:1]};
      logic_datapath_pkg::SH_SWAP:  shifted = {alu_raw[3:0], alu_raw[7:4]};
      default:                      shifted = alu_raw;
    endcase
    result = mask_en ? (shifted | OR_MASK) : shifted;
  end

  // =====================================================
  // queues and their arbitration
  logic [1:0]        q_in_valid;
  logic [1:0]        q_in_ready;
  logic [1:0][W-1:0] q_in_data;
  logic [1:0]        q_out_valid;
  logic [1:0]        q_out_ready;
  logic [1:0][W-1:0] q_out_data;
  logic [1:0]        want_push;
  logic [1:0]        want_pop;
  logic [1:0]        dp_push;
  logic [1:0]        dp_pop;
  logic [1:0]        bus_push;
  logic [1:0]        bus_pop;
  logic [1:0]        bus_refused;
  logic              stall;

  always_comb begin
    stall = 1'b0;
    for (int i = 0; i < 2; i++) begin
      want_push[i] = qmode[i] == logic_datapath_pkg::QM_CAP_ACC
                  || qmode[i] == logic_datapath_pkg::QM_CAP_ALU;
      want_pop[i]  = qmode[i] == logic_datapath_pkg::QM_LOAD;
      // a full queue in a capture mode or an empty queue in load mode holds back the alu, the registers and both queues' datapath side; bus accesses go on
      stall = stall | (want_push[i] & ~q_in_ready[i]) | (want_pop[i] & ~q_out_valid[i]);
    end
    for (int i = 0; i < 2; i++) begin
      logic hit;
      hit = bus_sel_in == (logic_datapath_pkg::SEL_Q0 + 3'(i));
      dp_push[i] = ce_in & want_push[i] & ~stall;
      dp_pop[i]  = ce_in & want_pop[i] & ~stall;
      // the datapath owns a queue side it uses; bus access there is refused
      bus_push[i] = ce_in & bus_wr_en_in & hit & ~want_push[i] & q_in_ready[i];
      bus_pop[i]  = ce_in & bus_rd_en_in & hit & ~want_pop[i] & q_out_valid[i];
      bus_refused[i] = hit & ((bus_wr_en_in & ~bus_push[i]) | (bus_rd_en_in & ~bus_pop[i]));
      q_in_valid[i]  = dp_push[i] | bus_push[i];
      q_in_data[i]   = !dp_push[i] ? bus_wdata_in
                     : (qmode[i] == logic_datapath_pkg::QM_CAP_ACC) ? st.acc[i] : result;
      q_out_ready[i] = dp_pop[i] | bus_pop[i];
    end
  end

  for (genvar g = 0; g < 2; g++) begin : g_queue
    byte_queue #(
      .WIDTH (W),
      .DEPTH (QUEUE_DEPTH)
    ) u_queue (
      .sys_clk_in    (sys_clk_in),
      .reset_in      (reset_in),
      .ce_in         (ce_in),
      .in_valid_in   (q_in_valid[g]),
      .in_ready_out  (q_in_ready[g]),
      .in_data_in    (q_in_data[g]),
      .out_valid_out (q_out_valid[g]),
      .out_ready_in  (q_out_ready[g]),
      .out_data_out  (q_out_data[g])
    );
  end

  // =====================================================
  // register update
  always_comb begin
    next_st = st;
    if (ce_in) begin
      next_st.stall = stall;
      if (!stall) begin
        next_st.alu = result;
        for (int i = 0; i < 2; i++) begin
          if (dest[i]) begin
            next_st.acc[i] = result;
          end
          if (dp_pop[i] && load_acc) begin
            next_st.acc[i] = q_out_data[i];
          end
          if (dp_pop[i] && !load_acc) begin
            next_st.opr[i] = q_out_data[i];
          end
        end
      end
      // cpu or dma write wins over the datapath in the same cycle
      if (bus_wr_en_in) begin
        case (bus_sel_in)
          logic_datapath_pkg::SEL_ACC0: next_st.acc[0] = bus_wdata_in;
          logic_datapath_pkg::SEL_ACC1: next_st.acc[1] = bus_wdata_in;
          logic_datapath_pkg::SEL_OPR0: next_st.opr[0] = bus_wdata_in;
          logic_datapath_pkg::SEL_OPR1: next_st.opr[1] = bus_wdata_in;
          default: ;
        endcase
      end
      next_st.rdata = '0;
      case (bus_sel_in)
        logic_datapath_pkg::SEL_ACC0: next_st.rdata = st.acc[0];
        logic_datapath_pkg::SEL_ACC1: next_st.rdata = st.acc[1];
        logic_datapath_pkg::SEL_OPR0: next_st.rdata = st.opr[0];
        logic_datapath_pkg::SEL_OPR1: next_st.rdata = st.opr[1];
        logic_datapath_pkg::SEL_Q0:   next_st.rdata = q_out_data[0];
        logic_datapath_pkg::SEL_Q1:   next_st.rdata = q_out_data[1];
        default:                      next_st.rdata = '0;
      endcase
      next_st.err = (|bus_refused) | ((bus_wr_en_in | bus_rd_en_in) & (bus_sel_in > 3'h5));
      next_st.rvalid = bus_rd_en_in & ~next_st.err;
      if (!bus_rd_en_in) begin
        next_st.rdata = '0;
      end
      for (int i = 0; i < 2; i++) begin
        next_st.eq[i]      = st.acc[i] == st.opr[i];
        next_st.lt[i]      = st.acc[i] < st.opr[i];
        next_st.q_empty[i] = ~q_out_valid[i];
        next_st.q_full[i]  = ~q_in_ready[i];
      end
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      st         <= '0;
      st.acc     <= {2{logic_datapath_pkg::REG_RESET}};
      st.opr     <= {2{logic_datapath_pkg::REG_RESET}};
      st.q_empty <= 2'h3;
    end else begin
      st <= next_st;
    end
  end

  assign bus_rdata_out  = st.rdata;
  assign bus_rvalid_out = st.rvalid;
  assign bus_err_out    = st.err;
  assign alu_out        = st.alu;
  assign cmp_eq_out     = st.eq;
  assign cmp_lt_out     = st.lt;
  assign q_empty_out    = st.q_empty;
  assign q_full_out     = st.q_full;
  assign stall_out      = st.stall;

  // =====================================================
  // checks
  logic go;
  assign go = ce_in && !stall;

  property p_alu_add;
    @(posedge sys_clk_in) disable iff (reset_in)
      go && op == logic_datapath_pkg::OP_ADD && shift_sel == 2'h0 && !mask_en
        |=> alu_out == $past(add_ref);
  endproperty
  a_alu_add: assert property (p_alu_add)
    else $error("add result wrong");

  property p_pass;
    @(posedge sys_clk_in) disable iff (reset_in)
      go && op == logic_datapath_pkg::OP_PASS && shift_sel == 2'h0 && !mask_en
        |=> alu_out == $past(a_val);
  endproperty
  a_pass: assert property (p_pass)
    else $error("pass changed the operand");

  property p_swap_mask;
    @(posedge sys_clk_in) disable iff (reset_in)
      go && op == logic_datapath_pkg::OP_PASS && shift_sel == 2'h3 && mask_en
        |=> alu_out == ({$past(a_val[3:0]), $past(a_val[7:4])} | OR_MASK);
  endproperty
  a_swap_mask: assert property (p_swap_mask)
    else $error("swap with mask wrong");

  property p_acc_dest;
    @(posedge sys_clk_in) disable iff (reset_in)
      go && dest[0] && !dp_pop[0] && !(bus_wr_en_in && bus_sel_in == 3'h0)
        |=> st.acc[0] == alu_out;
  endproperty
  a_acc_dest: assert property (p_acc_dest)
    else $error("accumulator did not take result");

  property p_opr_source_only;
    @(posedge sys_clk_in) disable iff (reset_in)
      !(bus_wr_en_in && bus_sel_in == 3'h2) && !(dp_pop[0] && !load_acc)
        |=> $stable(st.opr[0]);
  endproperty
  a_opr_source_only: assert property (p_opr_source_only)
    else $error("operand register took alu data");

  property p_queue_load;
    @(posedge sys_clk_in) disable iff (reset_in)
      dp_pop[1] && !load_acc && !(bus_wr_en_in && bus_sel_in == 3'h3)
        |=> st.opr[1] == $past(q_out_data[1]);
  endproperty
  a_queue_load: assert property (p_queue_load)
    else $error("queue load missed");

  property p_capture_alu;
    @(posedge sys_clk_in) disable iff (reset_in)
      dp_push[0] && qmode[0] == 2'h2 |-> q_in_valid[0] && q_in_data[0] == result;
  endproperty
  a_capture_alu: assert property (p_capture_alu)
    else $error("queue did not capture alu output");

  property p_stall_freeze;
    @(posedge sys_clk_in) disable iff (reset_in)
      ce_in && stall && !bus_wr_en_in |=> $stable(st.acc) ##0 stall_out;
  endproperty
  a_stall_freeze: assert property (p_stall_freeze)
    else $error("accumulators moved during stall");
endmodule
`default_nettype wire

// ==== verif/fabric_sequencer.sv ====
// routing fabric model that steps the configuration address
`timescale 1ns/1ps
`default_nettype none
module fabric_sequencer (
  input  wire logic            sys_clk_in,
  input  wire logic            go_in,
  input  wire logic [7:0][2:0] prog_in,
  input  wire logic [3:0]      len_in,
  output logic      [2:0]      cfg_addr_out
);
  int idx;

  // =====================================================
  // one address per cycle, word zero outside a sequence
  always @(negedge sys_clk_in) begin
    if (go_in && idx < int'(len_in)) begin
      cfg_addr_out = prog_in[idx];
      idx = idx + 1;
    end else begin
      cfg_addr_out = 3'h0;
      if (!go_in) begin
        idx = 0;
      end
    end
  end
endmodule
`default_nettype wire

// ==== verif/tb_logic_datapath.sv ====
// self-checking bench of the programmable logic datapath
`timescale 1ns/1ps
`default_nettype none
module tb_logic_datapath;
  logic            sys_clk_in;
  logic            reset_in;
  logic            ce_in;
  logic [2:0]      cfg_addr_in;
  logic            cfg_wr_en_in;
  logic [2:0]      cfg_wr_addr_in;
  logic [15:0]     cfg_wr_data_in;
  logic            bus_wr_en_in;
  logic            bus_rd_en_in;
  logic [2:0]      bus_sel_in;
  logic [7:0]      bus_wdata_in;
  logic [7:0]      bus_rdata_out;
  logic            bus_rvalid_out;
  logic            bus_err_out;
  logic [7:0]      alu_out;
  logic [1:0]      cmp_eq_out;
  logic [1:0]      cmp_lt_out;
  logic [1:0]      q_empty_out;
  logic [1:0]      q_full_out;
  logic            stall_out;
  logic            go;
  logic [7:0][2:0] prog;
  logic [3:0]      prog_len;
  logic [7:0]      expv [8];
  int              bad_count;
  int              checks;

  logic_datapath u_logic_datapath (.sys_clk_in, .reset_in, .ce_in, .cfg_addr_in,
    .cfg_wr_en_in, .cfg_wr_addr_in, .cfg_wr_data_in, .bus_wr_en_in, .bus_rd_en_in,
    .bus_sel_in, .bus_wdata_in, .bus_rdata_out, .bus_rvalid_out, .bus_err_out, .alu_out,
    .cmp_eq_out, .cmp_lt_out, .q_empty_out, .q_full_out, .stall_out);

  fabric_sequencer u_fabric_sequencer (.sys_clk_in(sys_clk_in), .go_in(go),
    .prog_in(prog), .len_in(prog_len), .cfg_addr_out(cfg_addr_in));

  initial begin
    sys_clk_in = 1'b0;
    forever #20 sys_clk_in = ~sys_clk_in;
  end

  // =====================================================
  // helpers
  task automatic summarize();
    if (bad_count == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [7:0] calc(input logic [2:0] op, input logic [1:0] sh,
                                      input logic m, input logic [7:0] a, input logic [7:0] b);
    logic [7:0] r;
    case (op)
      3'h0: r = a + 8'h01;
      3'h1: r = a - 8'h01;
      3'h2: r = a + b;
      3'h3: r = a - b;
      3'h4: r = a & b;
      3'h5: r = a | b;
      3'h6: r = a ^ b;
      default: r = a;
    endcase
    if (sh == 2'h1) r = r << 1;
    if (sh == 2'h2) r = r >> 1;
    if (sh == 2'h3) r = {r[3:0], r[7:4]};
    if (m) r = r | logic_datapath_pkg::OR_MASK_DEFAULT;
    return r;
  endfunction

  // one strobe, answer judged one cycle later
  task automatic bus(input logic wr, input logic [2:0] sel, input logic [7:0] d,
                     input logic err, input logic [7:0] exp);
    @(negedge sys_clk_in);
    bus_wr_en_in <= wr;
    bus_rd_en_in <= !wr;
    bus_sel_in <= sel;
    bus_wdata_in <= d;
    @(negedge sys_clk_in);
    bus_wr_en_in <= 1'b0;
    bus_rd_en_in <= 1'b0;
    chk({6'h0, bus_err_out, bus_rvalid_out}, {6'h0, err, !wr && !err});
    if (!wr && !err) chk(bus_rdata_out, exp);
  endtask

  task automatic cfg_wr(input logic [2:0] a, input logic [15:0] w);
    @(negedge sys_clk_in);
    cfg_wr_en_in <= 1'b1;
    cfg_wr_addr_in <= a;
    cfg_wr_data_in <= w;
    @(negedge sys_clk_in);
    cfg_wr_en_in <= 1'b0;
  endtask

  // plays prog back to back, alu_out judged after every step
  task automatic run(input int n);
    @(negedge sys_clk_in);
    prog_len <= 4'(n);
    go <= 1'b1;
    @(negedge sys_clk_in);
    for (int i = 0; i < n; i++) begin
      @(negedge sys_clk_in);
      chk(alu_out, expv[i]);
    end
    go <= 1'b0;
  endtask

  // =====================================================
  // scenarios
  task automatic test_regs();
    bus(1'b1, 3'h0, 8'h5a, 1'b0, 8'h00);
    bus(1'b1, 3'h1, 8'h10, 1'b0, 8'h00);
    bus(1'b1, 3'h2, 8'h3c, 1'b0, 8'h00);
    bus(1'b1, 3'h3, 8'h20, 1'b0, 8'h00);
    bus(1'b0, 3'h0, 8'h00, 1'b0, 8'h5a);
    bus(1'b0, 3'h1, 8'h00, 1'b0, 8'h10);
    bus(1'b0, 3'h2, 8'h00, 1'b0, 8'h3c);
    bus(1'b0, 3'h3, 8'h00, 1'b0, 8'h20);
    bus(1'b0, 3'h6, 8'h00, 1'b1, 8'h00);
    bus(1'b1, 3'h7, 8'h77, 1'b1, 8'h00);
    chk({4'h0, cmp_eq_out, cmp_lt_out}, 8'h02);
  endtask

  task automatic test_queue();
    for (int i = 0; i < 4; i++) bus(1'b1, 3'h4, 8'(8'h81 + i), 1'b0, 8'h00);
    bus(1'b1, 3'h4, 8'hee, 1'b1, 8'h00);
    chk({6'h0, q_full_out}, 8'h01);
    for (int i = 0; i < 4; i++) bus(1'b0, 3'h4, 8'h00, 1'b0, 8'(8'h81 + i));
    bus(1'b0, 3'h4, 8'h00, 1'b1, 8'h00);
    chk({6'h0, q_empty_out}, 8'h03);
  endtask

  task automatic test_alu();
    for (int k = 0; k < 8; k++) begin
      cfg_wr(3'(k), {13'h0, 3'(k)});
      prog[k] = 3'(7 - k);
      expv[k] = calc(3'(7 - k), 2'h0, 1'b0, 8'h5a, 8'h3c);
    end
    run(8);
  endtask

  task automatic test_post();
    for (int s = 0; s < 4; s++) begin
      cfg_wr(3'(s), {7'h0, 1'(s), 2'(s), 3'h0, 3'(s + 4)});
      prog[s] = 3'(s);
      expv[s] = calc(3'(s + 4), 2'(s), 1'(s), 8'h5a, 8'h3c);
    end
    run(4);
  endtask

  task automatic test_capture();
    cfg_wr(3'h4, 16'h1202);
    cfg_wr(3'h5, 16'h9800);
    prog[0] = 3'h4;
    expv[0] = 8'h96;
    run(1);
    bus(1'b0, 3'h0, 8'h00, 1'b0, 8'h96);
    bus(1'b1, 3'h0, 8'h11, 1'b0, 8'h00);
    prog[0] = 3'h5;
    expv[0] = 8'h12;
    run(1);
    bus(1'b0, 3'h0, 8'h00, 1'b0, 8'h96);
    expv[0] = calc(3'h4, 2'h0, 1'b0, 8'h96, 8'h3c);
    run(1);
    chk({7'h0, stall_out}, 8'h01);
    bus(1'b0, 3'h0, 8'h00, 1'b0, 8'h96);
  endtask

  // clock enable low: a bus write must not land, outputs hold
  task automatic test_hold();
    @(negedge sys_clk_in);
    ce_in <= 1'b0;
    bus(1'b1, 3'h0, 8'hab, 1'b0, 8'h00);
    chk(alu_out, calc(3'h4, 2'h0, 1'b0, 8'h96, 8'h3c));
    ce_in <= 1'b1;
    bus(1'b0, 3'h0, 8'h00, 1'b0, 8'h96);
  endtask

  // queue one: capture accumulator, then load operand register
  task automatic test_queue_one();
    cfg_wr(3'h6, 16'h2408);
    cfg_wr(3'h7, 16'h600f);
    prog[0] = 3'h6;
    prog[1] = 3'h7;
    expv[0] = calc(3'h0, 2'h0, 1'b0, 8'h10, 8'h00);
    expv[1] = calc(3'h7, 2'h0, 1'b0, 8'h11, 8'h00);
    run(2);
    bus(1'b0, 3'h3, 8'h00, 1'b0, 8'h10);
    bus(1'b0, 3'h1, 8'h00, 1'b0, 8'h11);
  endtask

  // =====================================================
  // main sequence and watchdog
  initial begin
    reset_in = 1'b1;
    ce_in = 1'b1;
    cfg_wr_en_in = 1'b0;
    cfg_wr_addr_in = 3'h0;
    cfg_wr_data_in = 16'h0000;
    bus_wr_en_in = 1'b0;
    bus_rd_en_in = 1'b0;
    bus_sel_in = 3'h0;
    bus_wdata_in = 8'h00;
    go = 1'b0;
    prog = '0;
    prog_len = 4'h0;
    bad_count = 0;
    checks = 0;
    repeat (16) @(negedge sys_clk_in);
    reset_in <= 1'b0;
    @(negedge sys_clk_in);
    chk({q_empty_out, q_full_out, cmp_eq_out, cmp_lt_out}, 8'hcc);
    chk(alu_out, calc(3'h0, 2'h0, 1'b0, 8'h00, 8'h00));
    test_regs();
    test_queue();
    test_alu();
    test_post();
    test_capture();
    test_hold();
    test_queue_one();
    summarize();
  end

  initial begin
    #400000;
    bad_count++;
    summarize();
  end
endmodule
`default_nettype wire
